// >>> hw/qos_classifier_egress_scheduler.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Weighted mode serves 8 high, 4 middle, 2 low and 1 lowest frame a round.
// - Strict mode always serves the highest non-empty queue first.
// - Four levels exist and each port holds a configurable default level.
// - Priority type picks disabled, port, class, tos or either one first.
// - Port mode gives each frame its ingress port's default level.
// - Class exclusive mode maps only the class value through its table.
// - Tos exclusive mode maps only the tos value through its table.
// - Class-then-fallback uses the class value if present, else other rules.
// - Tos-then-fallback uses the tos value if present, else other rules.
// - An eight entry table maps each class value to one of four levels.
// - A 64 entry table maps each tos value to one of four levels.
// - Every tos table entry resets to the lowest level.
// - In tos exclusive and tos-then-fallback modes, an IP frame's tos value is looked up to find its level.
module qos_classifier_egress_scheduler
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              cls_valid,
   input  wire qos_pkg::cls_req_t cls_req,
   output logic                   cls_done,
   output logic      [1:0]        cls_queue,
   input  wire logic [3:0]        q_nonempty,
   input  wire logic              sched_req,
   output logic                   gnt_valid,
   output logic      [1:0]        gnt_queue
);

   localparam qos_pkg::state_t ST_RST = '{
      pready:    1'b0,
      pslverr:   1'b0,
      prdata:    32'h0,
      strict:    qos_pkg::STRICT_RST,
      ptype:     qos_pkg::PTYPE_RST,
      port_def:  qos_pkg::PORT_RST,
      cos_map:   qos_pkg::COS_RST,
      tos_map:   qos_pkg::TOS_RST,
      cred:      {qos_pkg::W_HIGH, qos_pkg::W_MIDDLE,
                  qos_pkg::W_LOW, qos_pkg::W_LOWEST},
      cls_done:  1'b0,
      cls_queue: qos_pkg::LVL_LOWEST,
      gnt_valid: 1'b0,
      gnt_queue: qos_pkg::LVL_LOWEST
   };

   qos_pkg::state_t st_q;
   qos_pkg::state_t st_d;

   //////////////////////////////////////////////////////////////////////////
   // Helpers

   // Two-bit level from a packed table
   function automatic logic [1:0] pick_level
   (
      input logic [127:0] tbl,
      input logic [5:0]   idx
   );
      return tbl[{idx, 1'b0} +: 2];
   endfunction

   // Index of the highest set request bit
   function automatic logic [1:0] highest(input logic [3:0] m);
      logic [1:0] q;
      q = qos_pkg::LVL_LOWEST;
      if (m[3])
         q = qos_pkg::LVL_HIGH;
      else if (m[2])
         q = qos_pkg::LVL_MIDDLE;
      else if (m[1])
         q = qos_pkg::LVL_LOW;
      return q;
   endfunction

   function automatic logic [1:0] classify
   (
      input qos_pkg::ptype_t   pt,
      input qos_pkg::cls_req_t r,
      input logic [15:0]       pd,
      input logic [15:0]       cm,
      input logic [127:0]      tm
   );
      logic [1:0] lp;
      logic [1:0] lc;
      logic [1:0] lt;
      logic [1:0] q;
      lp = pick_level({112'h0, pd}, {3'h0, r.port});
      lc = pick_level({112'h0, cm}, {3'h0, r.cos});
      lt = pick_level(tm, r.tos);
      case (pt)
         qos_pkg::PT_PORT:
            q = lp;
         qos_pkg::PT_CLASS_EXCLUSIVE:
            q = r.cos_valid ? lc : qos_pkg::LVL_LOWEST;
         qos_pkg::PT_TOS_EXCLUSIVE:
            q = r.ip_valid ? lt : qos_pkg::LVL_LOWEST;
         qos_pkg::PT_CLASS_THEN_FALLBACK:
            q = r.cos_valid ? lc : (r.ip_valid ? lt : lp);
         qos_pkg::PT_TOS_THEN_FALLBACK:
            q = r.ip_valid ? lt : (r.cos_valid ? lc : lp);
         default:
            q = qos_pkg::LVL_LOWEST;
      endcase
      return q;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic [3:0]      elig;
      logic [3:0]      avail;
      logic [1:0]      sel;
      logic [3:0][3:0] cr;
      st_d = st_q;
      elig = 4'h0;
      avail = 4'h0;
      sel = qos_pkg::LVL_LOWEST;
      cr = st_q.cred;
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
      st_d.cls_done = 1'b0;
      st_d.gnt_valid = 1'b0;

      // APB: one wait state, read data captured with pready
      if (psel && penable && !st_q.pready)
      begin
         st_d.pready = 1'b1;
         st_d.prdata = 32'h0;
         case (paddr)
            qos_pkg::ADDR_CTRL:
            begin
               st_d.prdata[qos_pkg::CTRL_STRICT_BIT] = st_q.strict;
               st_d.prdata[qos_pkg::CTRL_PTYPE_LSB +: 3] = st_q.ptype;
            end
            qos_pkg::ADDR_PORT:
               st_d.prdata[15:0] = st_q.port_def;
            qos_pkg::ADDR_COS:
               st_d.prdata[15:0] = st_q.cos_map;
            qos_pkg::ADDR_STATUS:
               st_d.prdata[17:0] = {st_q.gnt_queue, st_q.cred};
            qos_pkg::ADDR_TOS0:
               st_d.prdata = st_q.tos_map[31:0];
            qos_pkg::ADDR_TOS1:
               st_d.prdata = st_q.tos_map[63:32];
            qos_pkg::ADDR_TOS2:
               st_d.prdata = st_q.tos_map[95:64];
            qos_pkg::ADDR_TOS3:
               st_d.prdata = st_q.tos_map[127:96];
            default:
               st_d.pslverr = 1'b1;
         endcase
      end

      // Writes land on the completing edge only
      if (psel && penable && st_q.pready && pwrite)
      begin
         case (paddr)
            qos_pkg::ADDR_CTRL:
            begin
               st_d.strict = pwdata[qos_pkg::CTRL_STRICT_BIT];
               st_d.ptype =
                  qos_pkg::ptype_t'(pwdata[qos_pkg::CTRL_PTYPE_LSB +: 3]);
            end
            qos_pkg::ADDR_PORT:
               st_d.port_def = pwdata[15:0];
            qos_pkg::ADDR_COS:
               st_d.cos_map = pwdata[15:0];
            qos_pkg::ADDR_TOS0:
               st_d.tos_map[31:0] = pwdata;
            qos_pkg::ADDR_TOS1:
               st_d.tos_map[63:32] = pwdata;
            qos_pkg::ADDR_TOS2:
               st_d.tos_map[95:64] = pwdata;
            qos_pkg::ADDR_TOS3:
               st_d.tos_map[127:96] = pwdata;
            default:
               st_d.pslverr = 1'b0;
         endcase
      end

      // Classification, one cycle of latency
      if (cls_valid)
      begin
         st_d.cls_done = 1'b1;
         st_d.cls_queue = classify(st_q.ptype, cls_req, st_q.port_def,
                                   st_q.cos_map, st_q.tos_map);
      end

      // Egress pick; weighted mode stays work conserving by reloading
      // the round as soon as no backlogged queue has credit left
      if (sched_req && (q_nonempty != 4'h0))
      begin
         if (st_q.strict)
            sel = highest(q_nonempty);
         else
         begin
            for (int i = 0; i < 4; i++)
               avail[i] = (cr[i] != 4'h0);
            elig = q_nonempty & avail;
            if (elig == 4'h0)
            begin
               cr = {qos_pkg::W_HIGH, qos_pkg::W_MIDDLE,
                     qos_pkg::W_LOW, qos_pkg::W_LOWEST};
               elig = q_nonempty;
            end
            sel = highest(elig);
            cr[sel] = cr[sel] - 4'h1;
            st_d.cred = cr;
         end
         st_d.gnt_valid = 1'b1;
         st_d.gnt_queue = sel;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= ST_RST;
      else
         st_q <= st_d;
   end

   assign prdata    = st_q.prdata;
   assign pready    = st_q.pready;
   assign pslverr   = st_q.pslverr;
   assign cls_done  = st_q.cls_done;
   assign cls_queue = st_q.cls_queue;
   assign gnt_valid = st_q.gnt_valid;
   assign gnt_queue = st_q.gnt_queue;

   //////////////////////////////////////////////////////////////////////////
   // Checks

   chk_strict_top: assert property (
      @(posedge pclk) disable iff (!presetn)
      sched_req && st_q.strict && (q_nonempty != 4'h0)
      |=> gnt_valid && (gnt_queue == highest($past(q_nonempty))))
      else $error("strict pick not highest backlogged queue");

   chk_weight_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      sched_req && !st_q.strict && q_nonempty[3]
      && (st_q.cred[3] != 4'h0)
      |=> gnt_queue == qos_pkg::LVL_HIGH
      && st_q.cred[3] == $past(st_q.cred[3]) - 4'h1)
      else $error("weighted high credit not spent");

   chk_credit_cap: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_q.cred[3] <= qos_pkg::W_HIGH && st_q.cred[2] <= qos_pkg::W_MIDDLE
      && st_q.cred[1] <= qos_pkg::W_LOW && st_q.cred[0] <= qos_pkg::W_LOWEST)
      else $error("round credit above weight");

   chk_port_mode: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && st_q.ptype == qos_pkg::PT_PORT
      |=> cls_done && cls_queue ==
      $past(st_q.port_def[{cls_req.port, 1'b0} +: 2]))
      else $error("port mode level mismatch");

   chk_class_excl: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && cls_req.cos_valid
      && st_q.ptype == qos_pkg::PT_CLASS_EXCLUSIVE
      |=> cls_queue == $past(st_q.cos_map[{cls_req.cos, 1'b0} +: 2]))
      else $error("class map level mismatch");

   chk_tos_excl: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && cls_req.ip_valid
      && st_q.ptype == qos_pkg::PT_TOS_EXCLUSIVE
      |=> cls_queue == $past(st_q.tos_map[{cls_req.tos, 1'b0} +: 2]))
      else $error("tos map level mismatch");

   chk_class_fallback: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && !cls_req.cos_valid && !cls_req.ip_valid
      && st_q.ptype == qos_pkg::PT_CLASS_THEN_FALLBACK
      |=> cls_queue == $past(st_q.port_def[{cls_req.port, 1'b0} +: 2]))
      else $error("class fallback to port failed");

   chk_tos_fallback: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && !cls_req.ip_valid && cls_req.cos_valid
      && st_q.ptype == qos_pkg::PT_TOS_THEN_FALLBACK
      |=> cls_queue == $past(st_q.cos_map[{cls_req.cos, 1'b0} +: 2]))
      else $error("tos fallback to class failed");

   chk_unclassified_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && (st_q.ptype == qos_pkg::PT_DISABLED
      || (st_q.ptype == qos_pkg::PT_TOS_EXCLUSIVE && !cls_req.ip_valid))
      |=> cls_queue == qos_pkg::LVL_LOWEST)
      else $error("unclassified frame not lowest");

   chk_tos_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> st_q.tos_map == qos_pkg::TOS_RST)
      else $error("tos table not lowest after reset");

   chk_tos_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == qos_pkg::ADDR_TOS1
      |=> st_q.tos_map[63:32] == $past(pwdata))
      else $error("tos table write lost");

   chk_class_absent: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && !cls_req.cos_valid
      && st_q.ptype == qos_pkg::PT_CLASS_EXCLUSIVE
      |=> cls_queue == qos_pkg::LVL_LOWEST)
      else $error("untagged frame not lowest");

   chk_class_to_tos: assert property (
      @(posedge pclk) disable iff (!presetn)
      cls_valid && !cls_req.cos_valid && cls_req.ip_valid
      && st_q.ptype == qos_pkg::PT_CLASS_THEN_FALLBACK
      |=> cls_queue == $past(st_q.tos_map[{cls_req.tos, 1'b0} +: 2]))
      else $error("class fallback to tos failed");

   // A grant without a backlogged request would drain a frame twice
   chk_grant_needs_req: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(sched_req && q_nonempty != 4'h0) |=> !gnt_valid)
      else $error("grant without a request");

   chk_weight_lowest: assert property (
      @(posedge pclk) disable iff (!presetn)
      sched_req && !st_q.strict && q_nonempty == 4'h1
      && (st_q.cred[0] != 4'h0)
      |=> gnt_queue == qos_pkg::LVL_LOWEST
      && st_q.cred[0] == $past(st_q.cred[0]) - 4'h1)
      else $error("weighted lowest credit not spent");

endmodule

// >>> hw/qos_pkg.sv
package qos_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_PORT   = 8'h04;
   localparam logic [7:0] ADDR_COS    = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_TOS0   = 8'h10;
   localparam logic [7:0] ADDR_TOS1   = 8'h14;
   localparam logic [7:0] ADDR_TOS2   = 8'h18;
   localparam logic [7:0] ADDR_TOS3   = 8'h1c;

   // Control field positions
   localparam int CTRL_STRICT_BIT = 0;
   localparam int CTRL_PTYPE_LSB  = 4;

   // Queue levels, index order lowest to high
   localparam logic [1:0] LVL_LOWEST = 2'h0;
   localparam logic [1:0] LVL_LOW    = 2'h1;
   localparam logic [1:0] LVL_MIDDLE = 2'h2;
   localparam logic [1:0] LVL_HIGH   = 2'h3;

   // Frames per weighted round
   localparam logic [3:0] W_HIGH   = 4'h8;
   localparam logic [3:0] W_MIDDLE = 4'h4;
   localparam logic [3:0] W_LOW    = 4'h2;
   localparam logic [3:0] W_LOWEST = 4'h1;

   typedef enum logic [2:0] {
      PT_DISABLED,
      PT_PORT,
      PT_CLASS_EXCLUSIVE,
      PT_TOS_EXCLUSIVE,
      PT_CLASS_THEN_FALLBACK,
      PT_TOS_THEN_FALLBACK
   } ptype_t;

   // Reset values
   localparam logic         STRICT_RST = 1'b0;
   localparam ptype_t       PTYPE_RST  = PT_DISABLED;
   localparam logic [15:0]  PORT_RST   = 16'h0000;
   localparam logic [15:0]  COS_RST    = 16'h0000;
   localparam logic [127:0] TOS_RST    = 128'h0;

   typedef struct packed {
      logic [2:0] port;
      logic       cos_valid;
      logic [2:0] cos;
      logic       ip_valid;
      logic [5:0] tos;
   } cls_req_t;

   typedef struct packed {
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic             strict;
      ptype_t           ptype;
      logic [15:0]      port_def;
      logic [15:0]      cos_map;
      logic [127:0]     tos_map;
      logic [3:0][3:0]  cred;
      logic             cls_done;
      logic [1:0]       cls_queue;
      logic             gnt_valid;
      logic [1:0]       gnt_queue;
   } state_t;

endpackage

// >>> test/qos_tx_model.sv
`timescale 1ns/1ps

// Transmit side: frames waiting per queue, asks for one frame at a time
module qos_tx_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fill_en,
   input  wire logic [15:0] fill,
   input  wire logic        run,
   input  wire logic        gnt_valid,
   input  wire logic [1:0]  gnt_queue,
   output logic      [3:0]  q_nonempty,
   output logic             sched_req
);
   logic [3:0][3:0] cnt_q;
   logic            pend_q;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         q_nonempty[i] = cnt_q[i] != 4'h0;
   end

   // One request in flight, so the scheduler never sees stale counts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
         pend_q <= 1'b0;
         sched_req <= 1'b0;
      end
      else
      begin
         sched_req <= 1'b0;
         if (fill_en)
            cnt_q <= fill;
         if (gnt_valid)
         begin
            cnt_q[gnt_queue] <= cnt_q[gnt_queue] - 4'h1;
            pend_q <= 1'b0;
         end
         else if (run && !pend_q && q_nonempty != 4'h0)
         begin
            sched_req <= 1'b1;
            pend_q <= 1'b1;
         end
      end
   end
endmodule

// >>> test/test_qos_classifier_egress_scheduler.sv
`timescale 1ns/1ps

module test_qos_classifier_egress_scheduler;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic               cls_valid;
   qos_pkg::cls_req_t  cls_req;
   logic               cls_done;
   logic [1:0]         cls_queue;
   logic [3:0]         q_nonempty;
   logic               sched_req;
   logic               gnt_valid;
   logic [1:0]         gnt_queue;
   logic               fill_en;
   logic [15:0]        fill;
   logic               run;
   int                 error_cnt;
   int                 samples_checked;
   logic [1:0]         gq[$];
   logic [1:0]         eq[$];
   qos_pkg::cls_req_t  frm[5];

   qos_classifier_egress_scheduler dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cls_valid(cls_valid),
      .cls_req(cls_req), .cls_done(cls_done), .cls_queue(cls_queue),
      .q_nonempty(q_nonempty), .sched_req(sched_req),
      .gnt_valid(gnt_valid), .gnt_queue(gnt_queue)
   );

   qos_tx_model tx
   (
      .pclk(pclk), .presetn(presetn), .fill_en(fill_en), .fill(fill),
      .run(run), .gnt_valid(gnt_valid), .gnt_queue(gnt_queue),
      .q_nonempty(q_nonempty), .sched_req(sched_req)
   );

   initial
   begin
      pclk = 1'b0;
      forever
         #50 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      if (gnt_valid === 1'b1)
         gq.push_back(gnt_queue);
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t bus timeout", $time);
         end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic ee);
      logic [31:0] d;
      logic        r;
      apb(1'b0, a, 32'h0, d, r);
      chk(d, e, "read data");
      chk({31'h0, r}, {31'h0, ee}, "slave error");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        r;
      apb(1'b1, a, d, x, r);
   endtask

   // Model tables: port n -> n[1:0], class c -> 3-c[1:0], only tos 25 high
   function automatic logic [1:0] exp_q(input int pt,
                                        input qos_pkg::cls_req_t f);
      logic [1:0] pl;
      logic [1:0] cl;
      logic [1:0] tl;
      pl = f.port[1:0];
      cl = 2'h3 - f.cos[1:0];
      tl = (f.tos == 6'h19) ? 2'h3 : 2'h0;
      case (pt)
         1: return pl;
         2: return f.cos_valid ? cl : 2'h0;
         3: return f.ip_valid ? tl : 2'h0;
         4: return f.cos_valid ? cl : (f.ip_valid ? tl : pl);
         5: return f.ip_valid ? tl : (f.cos_valid ? cl : pl);
         default: return 2'h0;
      endcase
   endfunction

   task automatic classify(input qos_pkg::cls_req_t r, input logic [1:0] e);
      @(posedge pclk);
      cls_valid <= 1'b1;
      cls_req <= r;
      @(posedge pclk);
      cls_valid <= 1'b0;
      #1;
      chk({31'h0, cls_done}, 32'h1, "done");
      chk({30'h0, cls_queue}, {30'h0, e}, "queue");
      @(posedge pclk);
      #1;
      chk({31'h0, cls_done}, 32'h0, "done pulse");
   endtask

   // Grants are compared in order against eq
   task automatic sched_run(input logic [15:0] c);
      int n;
      gq.delete();
      @(posedge pclk);
      fill_en <= 1'b1;
      fill <= c;
      @(posedge pclk);
      fill_en <= 1'b0;
      run <= 1'b1;
      n = 0;
      while (gq.size() < eq.size() && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      run <= 1'b0;
      chk(gq.size(), eq.size(), "grant count");
      foreach (eq[i])
         chk({30'h0, gq[i]}, {30'h0, eq[i]}, "grant order");
      if (n == 400)
         end_sim;
   endtask

   initial
   begin
      error_cnt = 0;
      samples_checked = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, cls_valid, fill_en, run} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cls_req = '0;
      fill = 16'h0000;
      frm = '{{3'h2, 1'b1, 3'h1, 1'b1, 6'h19},
              {3'h3, 1'b0, 3'h0, 1'b1, 6'h19},
              {3'h1, 1'b1, 3'h0, 1'b0, 6'h00},
              {3'h2, 1'b0, 3'h5, 1'b0, 6'h19},
              {3'h3, 1'b0, 3'h0, 1'b1, 6'h07}};
      repeat (5)
         @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(qos_pkg::ADDR_CTRL, 32'h0, 1'b0);
      rd_chk(qos_pkg::ADDR_PORT, 32'h0, 1'b0);
      rd_chk(qos_pkg::ADDR_COS, 32'h0, 1'b0);
      rd_chk(qos_pkg::ADDR_STATUS, 32'h8421, 1'b0);
      for (int i = 0; i < 4; i++)
         rd_chk(8'h10 + 8'(4 * i), 32'h0, 1'b0);
      rd_chk(8'h20, 32'h0, 1'b1);
      $display("test reset values done");
      wr(qos_pkg::ADDR_PORT, 32'he4e4);
      wr(qos_pkg::ADDR_COS, 32'h1b1b);
      wr(qos_pkg::ADDR_TOS1, 32'h000c0000);
      rd_chk(qos_pkg::ADDR_TOS1, 32'h000c0000, 1'b0);
      for (int pt = 0; pt < 6; pt++)
      begin
         wr(qos_pkg::ADDR_CTRL, 32'(pt) << qos_pkg::CTRL_PTYPE_LSB);
         foreach (frm[i])
            classify(frm[i], exp_q(pt, frm[i]));
      end
      $display("test classify done");
      wr(qos_pkg::ADDR_CTRL, 32'h1);
      eq = '{2'h2, 2'h2, 2'h1, 2'h0};
      sched_run(16'h0211);
      $display("test strict done");
      wr(qos_pkg::ADDR_CTRL, 32'h0);
      eq.delete();
      for (int q = 3; q >= 0; q--)
         repeat (1 << q)
            eq.push_back(2'(q));
      for (int q = 3; q >= 0; q--)
         eq.push_back(2'(q));
      sched_run(16'h9532);
      rd_chk(qos_pkg::ADDR_STATUS, 32'h7310, 1'b0);
      $display("test weighted done");
      end_sim;
   end

   initial
   begin
      #3000000;
      error_cnt++;
      $display("CHECK FAILED %0t run timeout", $time);
      end_sim;
   end
endmodule
